// *** rtl/trp_thermal_pg_cmds.sv ***
// Purpose: thermal fault response and output-ok assert threshold commands, with status and alert
// Assumes: command strobes come from the management-bus front end, one cycle each, synchronous
// Notes: the analog sensing is outside; this block sees a fault level and a scaled output reading
//
// Summary of operation
// RULE1 - thermal fault sets summary temperature bit, thermal fault bit, and raises alert
// RULE2 - thermal trip level is fixed; writes to other codes are refused
// RULE3 - thermal action byte: only bit 6 writable, resets to C0
// RULE4 - retry flag 0: stay shut down after a thermal fault, never restart
// RULE5 - retry flag 1: soft-start again once die temperature drops below hysteresis
// RULE6 - release output-ok pin high when output enters the assert window
// RULE7 - assert setting drives symmetric window; one write updates both limits
// RULE8 - written value is the low limit, snapped to 95, 92 or 90 percent
// RULE9 - after reset the assert window is 92 and 108 percent
// RULE10 - written value decodes as linear with exponent -10
// RULE11 - requested voltage becomes a percentage through the feedback divider ratio
// RULE12 - assert at or below deassert level flags comm fault, invalid data, alert
// RULE13 - out-of-range write is accepted but flags comm fault, invalid data, alert
// RULE14 - out-of-range write clamps to the nearest extreme window
// RULE15 - assert level is a 16-bit word with read-only zero msb
// RULE16 - store-defaults copies both settings to non-volatile memory
// RULE17 - host keeps assert level sensibly above the deassert level
// RULE18 - output-ok pin pulled low outside the selected deassert window, 90 percent default
// RULE19 - host reads status after alert to find the cause
`timescale 1ns/1ps
module trp_thermal_pg_cmds (
   input wire logic i_clock,
   input wire logic i_reset,
   input trp_pkg::trp_cmd_t i_cmd,
   input wire logic i_store_defaults,
   input wire logic i_clear_faults,
   input wire logic i_over_temp,
   input wire logic i_temp_below_hyst,
   input wire logic [15:0] i_feedback_divider_ratio,
   input wire logic [15:0] i_deassert_level,
   input trp_pkg::trp_deassert_win_t i_deassert_window,
   input wire logic [10:0] i_vout_permille,
   input wire logic i_output_ok_pin_in,
   output logic o_output_ok_pin_out,
   output logic o_output_ok_pin_oe_n,
   output logic o_alert_line,
   output logic o_converter_enable,
   output logic o_soft_start,
   output logic [15:0] o_read_data,
   output logic o_read_valid,
   output logic o_cmd_refused,
   output logic o_nvm_write,
   output trp_pkg::trp_nvm_t o_nvm_data,
   output trp_pkg::trp_assert_win_t o_assert_window,
   output logic [7:0] o_status_summary
);
   import trp_pkg::*;

   typedef struct packed {
      trp_therm_state_t therm;
      logic ot_prev;
      logic thermal_retry_flag;
      logic [14:0] assert_level;
      trp_assert_win_t assert_win;
      trp_status_t status;
      logic output_ok;
      logic soft_start;
      logic [15:0] read_data;
      logic read_valid;
      logic refused;
      logic nvm_write;
      trp_nvm_t nvm_data;
   } trp_state_t;

   trp_state_t s;
   trp_state_t next_s;
   trp_assert_win_t map_window;
   logic map_out_of_range;
   logic ot_rise;
   logic pg_write;
   logic pg_invalid;
   logic [10:0] assert_low;
   logic [10:0] deassert_low;
   logic in_assert_window;
   logic in_deassert_window;
   logic [7:0] thermal_byte;

   // mapping uses the ratio in force at the moment of the write
   trp_pg_mapper u_mapper (
      .i_level(i_cmd.data[14:0]),
      .i_feedback_divider_ratio(i_feedback_divider_ratio),
      .o_window(map_window),
      .o_out_of_range(map_out_of_range)
   );

   always_comb begin
      case (s.assert_win)
         TRP_ASSERT_95: assert_low = ASSERT_LOW_95;
         TRP_ASSERT_92: assert_low = ASSERT_LOW_92;
         default: assert_low = ASSERT_LOW_90;
      endcase
      case (i_deassert_window)
         TRP_DEASSERT_92: deassert_low = DEASSERT_LOW_92;
         TRP_DEASSERT_88: deassert_low = DEASSERT_LOW_88;
         default: deassert_low = DEASSERT_LOW_90;
      endcase
   end

   always_comb begin
      // symmetric about nominal: high limit is 200 percent minus the low one
      in_assert_window = (i_vout_permille >= assert_low) &&
                         (i_vout_permille <= PERMILLE_FULL - assert_low); // RULE7
      in_deassert_window = (i_vout_permille >= deassert_low) &&
                           (i_vout_permille <= PERMILLE_FULL - deassert_low); // RULE18
      thermal_byte = THERMAL_FAULT_ACTION_FIXED;
      thermal_byte[THERMAL_RETRY_BIT] = s.thermal_retry_flag; // RULE3
      ot_rise = i_over_temp && !s.ot_prev;
      pg_write = i_cmd.write && (i_cmd.code == CMD_OUTPUT_OK_ASSERT_LEVEL);
      // the msb is forced clear, so the stored value is never negative
      pg_invalid = map_out_of_range ||
                   ($signed({1'b0, i_cmd.data[14:0]}) <= $signed(i_deassert_level)); // RULE12 RULE13
   end

   always_comb begin
      next_s = s;
      next_s.ot_prev = i_over_temp;
      next_s.soft_start = 1'b0;
      next_s.read_valid = 1'b0;
      next_s.refused = 1'b0;
      next_s.nvm_write = 1'b0;

      // clear first, so a fault in the same cycle still lands
      if (i_clear_faults) begin
         next_s.status = '0;
      end

      if (ot_rise) begin
         next_s.status.summary[SUMMARY_TEMPERATURE_BIT] = 1'b1; // RULE1
         next_s.status.thermal[THERMAL_OT_FAULT_BIT] = 1'b1; // RULE1
      end

      // trip decision comes from the fixed internal comparator only
      case (s.therm)
         TRP_RUN: begin
            if (i_over_temp) begin
               next_s.therm = TRP_SHUTDOWN;
            end
         end
         TRP_SHUTDOWN: begin
            // with retry clear there is no exit short of reset
            if (s.thermal_retry_flag && i_temp_below_hyst && !i_over_temp) begin // RULE4 RULE5
               next_s.therm = TRP_RUN;
               next_s.soft_start = 1'b1; // RULE5
            end
         end
         default: begin
            next_s.therm = TRP_SHUTDOWN;
         end
      endcase

      if (i_cmd.write) begin
         if (i_cmd.code == CMD_THERMAL_FAULT_ACTION) begin
            next_s.thermal_retry_flag = i_cmd.data[THERMAL_RETRY_BIT]; // RULE3
         end else if (pg_write) begin
            // accepted even when invalid; window is clamped by the mapper
            next_s.assert_level = i_cmd.data[14:0]; // RULE15 RULE10
            next_s.assert_win = map_window; // RULE7 RULE8 RULE11 RULE14
            if (pg_invalid) begin
               next_s.status.summary[SUMMARY_COMM_FAULT_BIT] = 1'b1; // RULE12 RULE13
               next_s.status.comm_logic_status[COMM_INVALID_DATA_BIT] = 1'b1; // RULE12 RULE13
            end
         end else begin
            // includes any attempt to program the thermal trip level
            next_s.refused = 1'b1; // RULE2
         end
      end

      if (i_cmd.read) begin
         next_s.read_valid = 1'b1;
         if (i_cmd.code == CMD_THERMAL_FAULT_ACTION) begin
            next_s.read_data = {8'h00, thermal_byte};
         end else if (i_cmd.code == CMD_OUTPUT_OK_ASSERT_LEVEL) begin
            next_s.read_data = {1'b0, s.assert_level} & OUTPUT_OK_ASSERT_LEVEL_MASK; // RULE15
         end else if (i_cmd.code == CMD_STATUS_SUMMARY) begin
            next_s.read_data = {8'h00, s.status.summary};
         end else if (i_cmd.code == CMD_STATUS_THERMAL) begin
            next_s.read_data = {8'h00, s.status.thermal};
         end else if (i_cmd.code == CMD_COMM_LOGIC_STATUS) begin
            next_s.read_data = {8'h00, s.status.comm_logic_status};
         end else begin
            next_s.read_data = 16'h0000;
            next_s.refused = 1'b1;
         end
      end

      if (i_store_defaults) begin
         next_s.nvm_write = 1'b1; // RULE16
         next_s.nvm_data.thermal_fault_action = thermal_byte; // RULE16
         next_s.nvm_data.output_ok_assert_level = {1'b0, s.assert_level}; // RULE16
      end

      // hysteresis: rise on the assert window, fall on the separately selected deassert window
      if (s.therm != TRP_RUN) begin
         next_s.output_ok = 1'b0;
      end else if (s.output_ok) begin
         if (!in_deassert_window) begin
            next_s.output_ok = 1'b0; // RULE18
         end
      end else if (in_assert_window) begin
         next_s.output_ok = 1'b1; // RULE6
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         s.therm <= TRP_RUN;
         s.ot_prev <= 1'b0;
         s.thermal_retry_flag <= THERMAL_FAULT_ACTION_RESET[THERMAL_RETRY_BIT]; // RULE3
         s.assert_level <= OUTPUT_OK_ASSERT_LEVEL_RESET[14:0];
         s.assert_win <= TRP_ASSERT_92; // RULE9
         s.status <= '0;
         s.output_ok <= 1'b0;
         s.soft_start <= 1'b0;
         s.read_data <= 16'h0000;
         s.read_valid <= 1'b0;
         s.refused <= 1'b0;
         s.nvm_write <= 1'b0;
         s.nvm_data <= '0;
      end else begin
         s <= next_s;
      end
   end

   // open drain: pull low when not ok, release otherwise
   assign o_output_ok_pin_out = 1'b0;
   assign o_output_ok_pin_oe_n = s.output_ok; // RULE6 RULE18
   // alert stays up until software clears the status bits
   assign o_alert_line = |{s.status.summary, s.status.thermal, s.status.comm_logic_status}; // RULE1 RULE12 RULE13
   assign o_converter_enable = (s.therm == TRP_RUN); // RULE4
   assign o_soft_start = s.soft_start;
   assign o_read_data = s.read_data;
   assign o_read_valid = s.read_valid;
   assign o_cmd_refused = s.refused;
   assign o_nvm_write = s.nvm_write;
   assign o_nvm_data = s.nvm_data;
   assign o_assert_window = s.assert_win;
   assign o_status_summary = s.status.summary;

endmodule

// *** rtl/trp_pkg.sv ***
// Purpose: shared constants and types for the thermal response and output-ok threshold commands
// Assumes: command codes and status layout as used by the management-bus front end
// Notes: voltages are handled as raw linear words with a fixed exponent of -10
package trp_pkg;

   // command codes
   localparam logic [7:0] CMD_THERMAL_FAULT_ACTION = 8'h50;
   localparam logic [7:0] CMD_OUTPUT_OK_ASSERT_LEVEL = 8'h5E;
   localparam logic [7:0] CMD_STATUS_SUMMARY = 8'h78;
   localparam logic [7:0] CMD_STATUS_THERMAL = 8'h7D;
   localparam logic [7:0] CMD_COMM_LOGIC_STATUS = 8'h7E;

   // thermal_fault_action layout
   localparam int THERMAL_RETRY_BIT = 6;
   localparam logic [7:0] THERMAL_FAULT_ACTION_RESET = 8'hC0;
   localparam logic [7:0] THERMAL_FAULT_ACTION_FIXED = 8'h80;

   // output_ok_assert_level: msb read-only zero, 0x046A is 1.1035 V
   localparam logic [15:0] OUTPUT_OK_ASSERT_LEVEL_RESET = 16'h046A;
   localparam logic [15:0] OUTPUT_OK_ASSERT_LEVEL_MASK = 16'h7FFF;

   // status bit positions
   localparam int SUMMARY_TEMPERATURE_BIT = 2;
   localparam int SUMMARY_COMM_FAULT_BIT = 1;
   localparam int THERMAL_OT_FAULT_BIT = 7;
   localparam int COMM_INVALID_DATA_BIT = 6;

   // window limits in tenths of a percent of nominal
   localparam logic [10:0] PERMILLE_FULL = 11'h7D0;
   localparam logic [10:0] ASSERT_LOW_95 = 11'h3B6;
   localparam logic [10:0] ASSERT_LOW_92 = 11'h398;
   localparam logic [10:0] ASSERT_LOW_90 = 11'h384;
   localparam logic [10:0] DEASSERT_LOW_92 = 11'h398;
   localparam logic [10:0] DEASSERT_LOW_90 = 11'h384;
   localparam logic [10:0] DEASSERT_LOW_88 = 11'h370;

   // feedback-referred decision points, scaled by 2^20 (level 2^-10 times ratio 2^-10)
   // reference 600 mV: point = 0.6 * permille / 1000 * 2^20
   localparam logic [31:0] FB_RANGE_LOW = 32'((64'h258 * 64'h352 * 64'h100000) / 64'hF4240);
   localparam logic [31:0] FB_MID_90_92 = 32'((64'h258 * 64'h38E * 64'h100000) / 64'hF4240);
   localparam logic [31:0] FB_MID_92_95 = 32'((64'h258 * 64'h3A7 * 64'h100000) / 64'hF4240);
   localparam logic [31:0] FB_RANGE_HIGH = 32'((64'h258 * 64'h3E8 * 64'h100000) / 64'hF4240);

   typedef enum logic [1:0] {TRP_ASSERT_95, TRP_ASSERT_92, TRP_ASSERT_90} trp_assert_win_t;
   typedef enum logic [1:0] {TRP_DEASSERT_92, TRP_DEASSERT_90, TRP_DEASSERT_88} trp_deassert_win_t;
   typedef enum logic {TRP_RUN, TRP_SHUTDOWN} trp_therm_state_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] code;
      logic [15:0] data;
   } trp_cmd_t;

   typedef struct packed {
      logic [7:0] thermal_fault_action;
      logic [15:0] output_ok_assert_level;
   } trp_nvm_t;

   typedef struct packed {
      logic [7:0] summary;
      logic [7:0] thermal;
      logic [7:0] comm_logic_status;
   } trp_status_t;

endpackage

// *** rtl/trp_pg_mapper.sv ***
// Purpose: maps a requested output-ok assert level to a supported symmetric window
// Assumes: level in units of 2^-10 V, divider ratio in units of 2^-10
// Notes: purely combinational; compares on the feedback side against the 600 mV reference
`timescale 1ns/1ps
module trp_pg_mapper (
   input wire logic [14:0] i_level,
   input wire logic [15:0] i_feedback_divider_ratio,
   output trp_pkg::trp_assert_win_t o_window,
   output logic o_out_of_range
);
   import trp_pkg::*;

   logic [31:0] fb;

   always_comb begin
      // level times ratio is at most 31 bits, so no overflow
      fb = 32'(i_level) * 32'(i_feedback_divider_ratio);
      o_out_of_range = (fb < FB_RANGE_LOW) || (fb >= FB_RANGE_HIGH);
      // nearest pair; anything outside the range lands on the nearest extreme
      if (fb < FB_MID_90_92) begin
         o_window = TRP_ASSERT_90;
      end else if (fb < FB_MID_92_95) begin
         o_window = TRP_ASSERT_92;
      end else begin
         o_window = TRP_ASSERT_95;
      end
   end
endmodule

// *** sim/trp_host.sv ***
// Purpose: host model that issues command strobes to the thermal and output-ok command block
// Assumes: one request at a time, launched on a falling edge and taken on the next rising edge
// Notes: idle code and data show the inverse of the last request, never a stale copy
`timescale 1ns/1ps
module trp_host (
   input wire logic i_clock,
   output trp_pkg::trp_cmd_t o_cmd
);
   import trp_pkg::*;
   initial o_cmd = '0;
   task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(negedge i_clock);
      o_cmd = '{write: w, read: !w, code: c, data: d};
      @(negedge i_clock);
      o_cmd = '{write: 1'b0, read: 1'b0, code: ~c, data: ~d};
   endtask
endmodule

// *** sim/trp_thermal_pg_cmds_props.sv ***
// Purpose: port-level checks of the thermal response and output-ok threshold commands
// Assumes: single clock domain, asynchronous active-high reset
// Notes: retry flag is internal, so shutdown persistence is judged by the bench
`timescale 1ns/1ps
module trp_props (
   input wire logic i_clock,
   input wire logic i_reset,
   input trp_pkg::trp_cmd_t i_cmd,
   input wire logic i_store_defaults,
   input wire logic i_over_temp,
   input wire logic i_temp_below_hyst,
   input wire logic [15:0] i_deassert_level,
   input wire logic o_output_ok_pin_out,
   input wire logic o_output_ok_pin_oe_n,
   input wire logic o_alert_line,
   input wire logic o_converter_enable,
   input wire logic o_soft_start,
   input wire logic [15:0] o_read_data,
   input wire logic o_read_valid,
   input wire logic o_cmd_refused,
   input wire logic o_nvm_write,
   input trp_pkg::trp_assert_win_t o_assert_window,
   input wire logic [7:0] o_status_summary
);
   import trp_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   sequence s_heat; $rose(i_over_temp); endsequence
   sequence s_trip; o_alert_line && o_status_summary[SUMMARY_TEMPERATURE_BIT] && !o_converter_enable; endsequence
   chk_ot_trip: assert property (s_heat |=> s_trip) else $error("thermal trip not flagged");
   chk_bad_code: assert property (i_cmd.write && i_cmd.code != CMD_THERMAL_FAULT_ACTION
      && i_cmd.code != CMD_OUTPUT_OK_ASSERT_LEVEL |=> o_cmd_refused) else $error("write not refused");
   chk_action_byte: assert property (i_cmd.read && i_cmd.code == CMD_THERMAL_FAULT_ACTION
      |=> o_read_valid && o_read_data[15:7] == 9'h001 && o_read_data[5:0] == 6'h00) else $error("action byte");
   chk_level_msb: assert property (i_cmd.read && i_cmd.code == CMD_OUTPUT_OK_ASSERT_LEVEL
      |=> o_read_valid && !o_read_data[15]) else $error("level msb set");
   chk_restart_cause: assert property (o_soft_start |-> o_converter_enable
      && $past(i_temp_below_hyst && !i_over_temp)) else $error("restart without cooling");
   chk_window_hold: assert property (!(i_cmd.write && i_cmd.code == CMD_OUTPUT_OK_ASSERT_LEVEL)
      |=> $stable(o_assert_window)) else $error("window moved");
   chk_store_pulse: assert property (o_nvm_write == $past(i_store_defaults)) else $error("store pulse");
   chk_alert_cause: assert property (o_status_summary[2:1] != 2'b00 |-> o_alert_line) else $error("no alert");
   chk_shut_pin: assert property (!o_converter_enable |=> !o_output_ok_pin_oe_n) else $error("pin ok");
   chk_low_assert: assert property (i_cmd.write && i_cmd.code == CMD_OUTPUT_OK_ASSERT_LEVEL
      && ($signed({1'b0, i_cmd.data[14:0]}) <= $signed(i_deassert_level))
      |=> o_alert_line && o_status_summary[SUMMARY_COMM_FAULT_BIT]) else $error("low assert level not flagged");
   chk_pin_drive: assert property (!o_output_ok_pin_oe_n |-> !o_output_ok_pin_out) else $error("pin not low");
endmodule
bind trp_thermal_pg_cmds trp_props u_props (.*);

// *** sim/tb_trp_thermal_pg_cmds.sv ***
// Purpose: self-checking bench for the thermal response and output-ok threshold commands
// Assumes: divider ratio 0.5 gives 1.2 V nominal, so level words map to permille of 1228.8 counts
// Notes: read answers are queued by the driver and matched by a monitor on the falling edge
`timescale 1ns/1ps
module tb_trp_thermal_pg_cmds;
   import trp_pkg::*;
   logic i_clock = 0, i_reset = 1, store = 0, clr = 0, ot = 0, cool = 0;
   logic [15:0] ratio = 16'h0200, deass = 16'h0400, rd;
   logic [10:0] vout = 11'h3E8;
   logic oe_n, alert, en, ss, rv, nvw, refd;
   trp_cmd_t cmd;
   trp_nvm_t nvd;
   trp_assert_win_t win;
   trp_deassert_win_t dwin = TRP_DEASSERT_90;
   logic [7:0] summ;
   int mismatches = 0, samples_checked = 0;
   integer seed = 32'hF7CC;
   logic [15:0] expq[$];
   logic [15:0] lv[6] = '{16'h048F, 16'h046B, 16'h0452, 16'h0400, 16'h0533, 16'hFFFF};
   trp_assert_win_t wv[6] = '{TRP_ASSERT_95, TRP_ASSERT_92, TRP_ASSERT_90, TRP_ASSERT_90, TRP_ASSERT_95, TRP_ASSERT_95};
   logic [5:0] bad = 6'b111000;
   trp_host host (.i_clock(i_clock), .o_cmd(cmd));
   trp_thermal_pg_cmds uut (.i_clock(i_clock), .i_reset(i_reset), .i_cmd(cmd), .i_store_defaults(store),
      .i_clear_faults(clr), .i_over_temp(ot), .i_temp_below_hyst(cool), .i_feedback_divider_ratio(ratio),
      .i_deassert_level(deass), .i_deassert_window(dwin), .i_vout_permille(vout),
      .i_output_ok_pin_in(oe_n), .o_output_ok_pin_out(), .o_output_ok_pin_oe_n(oe_n), .o_alert_line(alert),
      .o_converter_enable(en), .o_soft_start(ss), .o_read_data(rd), .o_read_valid(rv), .o_cmd_refused(refd),
      .o_nvm_write(nvw), .o_nvm_data(nvd), .o_assert_window(win), .o_status_summary(summ));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (expq.size() != 0) mismatches++;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      host.issue(1'b1, c, d);
   endtask
   task automatic rdq(input logic [7:0] c, input logic [15:0] e);
      expq.push_back(e);
      host.issue(1'b0, c, 16'h0000);
   endtask
   task automatic settle;
      @(negedge i_clock);
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clock) s = 1'b1;
      @(negedge i_clock) s = 1'b0;
   endtask
   always @(negedge i_clock) if (rv === 1'b1) chk(rd, (expq.size() != 0) ? expq.pop_front() : 16'hDEAD);
   initial forever #4 i_clock = ~i_clock;
   initial begin
      #50000;
      mismatches++;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge i_clock);
      @(negedge i_clock) i_reset = 1'b0;
      rdq(CMD_THERMAL_FAULT_ACTION, 16'h00C0);
      rdq(CMD_OUTPUT_OK_ASSERT_LEVEL, 16'h046A);
      chk(16'(win), 16'(TRP_ASSERT_92));
      wr(CMD_THERMAL_FAULT_ACTION, 16'hFFFF);
      rdq(CMD_THERMAL_FAULT_ACTION, 16'h00C0);
      wr(CMD_THERMAL_FAULT_ACTION, 16'h0000);
      rdq(CMD_THERMAL_FAULT_ACTION, 16'h0080);
      wr(8'h4F, 16'h00FF);
      chk(16'(refd), 16'h0001);
      rdq(8'h4F, 16'h0000);
      chk(16'(refd), 16'h0001);
      foreach (lv[i]) begin
         wr(CMD_OUTPUT_OK_ASSERT_LEVEL, lv[i]);
         settle;
         chk(16'(win), 16'(wv[i]));
         chk(16'(summ[SUMMARY_COMM_FAULT_BIT]), 16'(bad[i]));
         rdq(CMD_OUTPUT_OK_ASSERT_LEVEL, lv[i] & 16'h7FFF);
         pulse(clr);
      end
      ratio = 16'h0400;
      deass = 16'h0100;
      wr(CMD_OUTPUT_OK_ASSERT_LEVEL, 16'h0226);
      settle;
      chk(16'(win), 16'(TRP_ASSERT_90));
      chk(16'(summ[SUMMARY_COMM_FAULT_BIT]), 16'h0000);
      ratio = 16'h0200;
      deass = 16'h046B;
      wr(CMD_OUTPUT_OK_ASSERT_LEVEL, 16'h046B);
      settle;
      chk(16'(win), 16'(TRP_ASSERT_92));
      chk({14'h0000, summ[SUMMARY_COMM_FAULT_BIT], alert}, 16'h0003);
      rdq(CMD_COMM_LOGIC_STATUS, 16'h0040);
      rdq(CMD_STATUS_SUMMARY, 16'h0002);
      deass = 16'h0400;
      pulse(clr);
      pulse(store);
      chk(16'(nvw), 16'h0001);
      chk({8'h00, nvd.thermal_fault_action}, 16'h0080);
      chk(nvd.output_ok_assert_level, 16'h046B);
      wr(CMD_THERMAL_FAULT_ACTION, 16'h0040);
      // random readings stay inside both windows, so the pin must stay released
      repeat (20) @(negedge i_clock) vout = 11'(960 + {$random(seed)} % 80);
      chk(16'(oe_n), 16'h0001);
      vout = 11'h352;
      repeat (2) settle;
      chk(16'(oe_n), 16'h0000);
      vout = 11'h3E8;
      repeat (2) settle;
      chk(16'(oe_n), 16'h0001);
      // 89.0 percent holds the pin only with the widest deassert window
      dwin = TRP_DEASSERT_88;
      vout = 11'h37A;
      repeat (2) settle;
      chk(16'(oe_n), 16'h0001);
      dwin = TRP_DEASSERT_92;
      vout = 11'h38E;
      repeat (2) settle;
      chk(16'(oe_n), 16'h0000);
      dwin = TRP_DEASSERT_90;
      vout = 11'h3E8;
      repeat (2) settle;
      chk(16'(oe_n), 16'h0001);
      ot = 1'b1;
      settle;
      chk({13'h0000, en, alert, summ[SUMMARY_TEMPERATURE_BIT]}, 16'h0003);
      rdq(CMD_STATUS_THERMAL, 16'h0080);
      ot = 1'b0;
      cool = 1'b1;
      settle;
      chk({14'h0000, ss, en}, 16'h0003);
      cool = 1'b0;
      wr(CMD_THERMAL_FAULT_ACTION, 16'h0000);
      pulse(clr);
      ot = 1'b1;
      settle;
      ot = 1'b0;
      cool = 1'b1;
      repeat (10) settle;
      chk(16'(en), 16'h0000);
      cool = 1'b0;
      repeat (3) settle;
      wrap_up;
   end
endmodule
